/* File: rtl/spk_packetizer.sv */
// spk_packetizer: one serial port packetizer with host fan-out
// assumes: rx bytes, hosts and commands share sys_clk_i; link pin async
// Function
// [RULE_01] zero length limit means no count limit
// [RULE_02] release when count reaches length limit
// [RULE_03] first delimiter byte triggers release
// [RULE_04] both enabled: release only after both bytes
// [RULE_05] software keeps length zero with delimiters
// [RULE_06] delimiters still release above one kilobyte
// [RULE_07] policy ignored unless first delimiter enabled
// [RULE_08] plain policy releases at once, delimiter kept
// [RULE_09] plus-one policy waits one further byte
// [RULE_10] plus-two policy waits two further bytes
// [RULE_11] strip policy drops delimiter bytes
// [RULE_12] zero idle gap disables gap release
// [RULE_13] release when idle gap exceeds setting
// [RULE_14] one kilobyte buffer, full buffer releases
// [RULE_15] software sets gap above one character
// [RULE_16] low option drops rts dtr on link loss
// [RULE_17] wait all hosts unless jammed skipping on
// [RULE_18] one host full control, up to four tunnel
// [RULE_19] commands ignored unless enabled, latest wins
// [RULE_20] network to serial data kept in order
// [RULE_21] datagram needs one of four ranges set
// [RULE_22] range at most 64, .255 means broadcast
// [RULE_23] release clears count, match and gap timer
`timescale 1ns/100ps
module spk_packetizer
  import spk_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYC,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic ser_rx_valid_i,
  input wire logic [7:0] ser_rx_data_i,
  output logic ser_rx_ready_o,
  output logic net_tx_valid_o,
  output logic [7:0] net_tx_data_o,
  output logic net_tx_last_o,
  output logic [MAX_HOSTS-1:0] net_tx_pend_o,
  input wire logic [MAX_HOSTS-1:0] host_ready_i,
  input wire logic [MAX_HOSTS-1:0] host_jam_i,
  input wire logic net_rx_valid_i,
  input wire logic [7:0] net_rx_data_i,
  output logic net_rx_ready_o,
  output logic ser_tx_valid_o,
  output logic [7:0] ser_tx_data_o,
  input wire logic ser_tx_ready_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_rts_i,
  input wire logic cmd_dtr_i,
  input wire logic link_up_i,
  output logic rts_o,
  output logic dtr_o
);
  localparam int FW = $clog2(DEPTH) + 1; // fifo count width
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(BUF_BYTES);

  // ==========================================
  // configuration registers
  logic [7:0] ctrl_reg; // mode bits
  logic [CNT_W-1:0] len_reg; // length limit
  logic [19:0] dlm_reg; // delimiter setup
  logic [15:0] gap_reg; // idle gap ms
  logic [31:0] rbeg_reg [NRANGE]; // range begins
  logic [31:0] rend_reg [NRANGE]; // range ends
  logic [31:0] reg_rdata_reg; // read answer
  // ==========================================
  // packetizer state
  spk_st_t st_reg; // fill or drain
  logic [7:0] mem_reg [BUF_BYTES]; // packet buffer
  logic [CNT_W-1:0] cnt_reg; // bytes held
  logic [CNT_W-1:0] dlen_reg; // bytes to drain
  logic [CNT_W-1:0] rd_ptr_reg; // drain index
  logic prev_d1_reg; // last byte was first delimiter
  logic [1:0] trail_reg; // bytes still owed after match
  logic [$clog2(MS_CYCLES)-1:0] ms_div_reg; // ms divider
  logic [16:0] gap_ms_reg; // ms since last byte
  logic rx_rdy_reg; // accepting serial bytes
  logic tx_vld_reg; // byte on offer
  logic [7:0] tx_dat_reg; // offered byte
  logic tx_last_reg; // last of packet
  logic [MAX_HOSTS-1:0] pend_reg; // hosts still owed byte
  // ==========================================
  // fifo and line control
  logic [7:0] fifo_reg [DEPTH]; // network to serial store
  logic [FW-2:0] fwp_reg; // write index
  logic [FW-2:0] frp_reg; // read index
  logic [FW-1:0] fcnt_reg; // entries held
  logic nrx_rdy_reg; // fifo has room
  logic stx_vld_reg; // serial byte on offer
  logic [7:0] stx_dat_reg; // serial byte
  logic link_m_reg; // sync stage one
  logic link_s_reg; // synced link state
  logic rts_ctl_reg; // commanded rts
  logic dtr_ctl_reg; // commanded dtr
  logic rts_reg; // rts pin
  logic dtr_reg; // dtr pin

  // ==========================================
  // decoded settings
  logic en1, en2, skip, dgram, send_ok, take, dcond, strip, store, ms_tick;
  logic rel_dlm, rel_len, rel_full, rel_gap, flush, byte_done, cmd_ok;
  spk_pol_t pol;
  logic [2:0] maxc;
  logic [MAX_HOSTS-1:0] active, owed;
  logic [NRANGE-1:0] rng_ok;
  logic [CNT_W-1:0] cnt_next;
  logic [FW-1:0] fcnt_next;
  logic push, pop;

  assign en1 = dlm_reg[DLM_EN1];
  assign en2 = dlm_reg[DLM_EN2];
  assign pol = spk_pol_t'(dlm_reg[DLM_POL +: 2]);
  assign skip = ctrl_reg[CTRL_SKIP];
  assign dgram = ctrl_reg[CTRL_DGRAM];
  assign maxc = ctrl_reg[CTRL_MAXC +: 3];
  assign take = ser_rx_valid_i && rx_rdy_reg;
  assign ms_tick = ms_div_reg == ($clog2(MS_CYCLES))'(MS_CYCLES - 1);

  // range check per destination
  genvar gi;
  generate
    for (gi = 0; gi < NRANGE; gi++) begin : g_rng
      // broadcast begin or span within limit
      assign rng_ok[gi] = (rbeg_reg[gi] != 32'h00000000) && // RULE_21
        ((rbeg_reg[gi][7:0] == BCAST_OCTET) || // RULE_22
        ((rend_reg[gi] >= rbeg_reg[gi]) && (rend_reg[gi] - rbeg_reg[gi] < RANGE_SPAN)));
      // hosts admitted by max connections
      assign active[gi] = (32'(gi) < 32'(maxc)) || (gi == 0); // RULE_18
    end
  endgenerate

  // datagram mode sends only with a valid range
  assign send_ok = !dgram || (rng_ok != '0); // RULE_21

  // ==========================================
  // byte classification
  always_comb begin
    // both enabled: d1 then d2 back to back
    dcond = en1 && (en2 ? (prev_d1_reg && ser_rx_data_i == dlm_reg[15:8]) // RULE_04
      : (ser_rx_data_i == dlm_reg[7:0])); // RULE_03
    strip = dcond && pol == POL_STRIP; // RULE_11
    store = take && !strip;
    // stripped pair removes the stored d1 too
    if (take && strip && en2) begin
      cnt_next = cnt_reg - CNT_W'(1); // RULE_11
    end else if (store) begin
      cnt_next = cnt_reg + CNT_W'(1);
    end else begin
      cnt_next = cnt_reg;
    end
    // policy has no effect without first delimiter
    rel_dlm = take && en1 && ((dcond && trail_reg == 2'h0 && // RULE_07
      (pol == POL_PLAIN || pol == POL_STRIP)) || trail_reg == 2'h1); // RULE_08
    rel_len = take && len_reg != '0 && cnt_next >= len_reg; // RULE_01 RULE_02
    rel_full = cnt_next == FULL_CNT; // RULE_14 RULE_06
    rel_gap = gap_reg != 16'h0000 && cnt_reg != '0 && // RULE_12
      gap_ms_reg > {1'b0, gap_reg}; // RULE_13
    flush = st_reg == ST_FILL && (rel_dlm || rel_len || rel_full || rel_gap);
  end

  // current byte settled by every admitted host
  assign owed = pend_reg & ~host_ready_i & ~(skip ? host_jam_i : '0); // RULE_17
  assign byte_done = tx_vld_reg && owed == '0;

  // ==========================================
  // register writes
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg <= {1'b0, MAXC_RST, 4'h0};
      len_reg <= '0;
      dlm_reg <= {POL_RST, 18'h00000};
      gap_reg <= 16'h0000;
    end else if (reg_wr_i) begin
      // decode the written word
      unique case (reg_addr_i)
        CTRL_OFS: ctrl_reg <= reg_wdata_i[7:0];
        LEN_OFS: len_reg <= reg_wdata_i[CNT_W-1:0];
        DLM_OFS: dlm_reg <= reg_wdata_i[19:0];
        GAP_OFS: gap_reg <= reg_wdata_i[15:0];
        default: ; // ranges or unmapped
      endcase
    end
  end

  // range registers, one pair per destination
  generate
    for (gi = 0; gi < NRANGE; gi++) begin : g_rw
      always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          rbeg_reg[gi] <= 32'h00000000;
          rend_reg[gi] <= 32'h00000000;
        end else if (reg_wr_i && reg_addr_i == RNG_OFS + 8'(8 * gi)) begin
          rbeg_reg[gi] <= reg_wdata_i;
        end else if (reg_wr_i && reg_addr_i == RNG_OFS + 8'(8 * gi + 4)) begin
          rend_reg[gi] <= reg_wdata_i;
        end
      end
    end
  endgenerate

  // read answer, one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_reg <= 32'h00000000;
    end else begin
      reg_rdata_reg <= 32'h00000000;
      if (reg_rd_i) begin
        unique case (reg_addr_i)
          CTRL_OFS: reg_rdata_reg <= {24'h000000, ctrl_reg};
          LEN_OFS: reg_rdata_reg <= {21'h000000, len_reg};
          DLM_OFS: reg_rdata_reg <= {12'h000, dlm_reg};
          GAP_OFS: reg_rdata_reg <= {16'h0000, gap_reg};
          STAT_OFS: reg_rdata_reg <= {fcnt_reg[4:0], link_s_reg, send_ok, rng_ok,
            st_reg == ST_DRAIN, 9'h000, cnt_reg};
          default: begin
            // ranges by index, unmapped reads zero
            for (int i = 0; i < NRANGE; i++) begin
              if (reg_addr_i == RNG_OFS + 8'(8 * i)) reg_rdata_reg <= rbeg_reg[i];
              if (reg_addr_i == RNG_OFS + 8'(8 * i + 4)) reg_rdata_reg <= rend_reg[i];
            end
          end
        endcase
      end
    end
  end

  // ==========================================
  // buffer store
  always_ff @(posedge sys_clk_i) begin
    if (store) begin
      mem_reg[cnt_reg[9:0]] <= ser_rx_data_i; // RULE_14
    end
  end

  // delimiter tracking, cleared by every release
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_d1_reg <= 1'b0;
      trail_reg <= 2'h0;
    end else if (flush) begin
      prev_d1_reg <= 1'b0; // RULE_23
      trail_reg <= 2'h0; // RULE_23
    end else if (take) begin
      prev_d1_reg <= en1 && ser_rx_data_i == dlm_reg[7:0];
      if (trail_reg != 2'h0) begin
        trail_reg <= trail_reg - 2'h1;
      end else if (dcond && pol == POL_PLUS1) begin
        trail_reg <= 2'h1; // RULE_09
      end else if (dcond && pol == POL_PLUS2) begin
        trail_reg <= 2'h2; // RULE_10
      end
    end
  end

  // idle gap timer: ms divider restarts on each byte
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ms_div_reg <= '0;
      gap_ms_reg <= 17'h00000;
    end else if (take || flush) begin
      ms_div_reg <= '0; // RULE_23
      gap_ms_reg <= 17'h00000;
    end else if (ms_tick) begin
      ms_div_reg <= '0;
      if (gap_ms_reg != 17'h1FFFF) gap_ms_reg <= gap_ms_reg + 17'h00001; // RULE_13
    end else begin
      ms_div_reg <= ms_div_reg + 1'b1;
    end
  end

  // ==========================================
  // fill and drain control
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= ST_FILL;
      cnt_reg <= '0;
      dlen_reg <= '0;
      rd_ptr_reg <= '0;
      rx_rdy_reg <= 1'b0;
      tx_vld_reg <= 1'b0;
      tx_dat_reg <= 8'h00;
      tx_last_reg <= 1'b0;
      pend_reg <= '0;
    end else begin
      unique case (st_reg)
        ST_FILL: begin
          rx_rdy_reg <= 1'b1;
          if (flush && cnt_next != '0) begin
            // hand the buffer to the network side
            st_reg <= ST_DRAIN;
            dlen_reg <= cnt_next;
            rd_ptr_reg <= '0;
            cnt_reg <= '0; // RULE_23
            rx_rdy_reg <= 1'b0;
          end else if (flush) begin
            cnt_reg <= '0; // RULE_23
          end else begin
            cnt_reg <= cnt_next;
          end
        end
        ST_DRAIN: begin
          if (!tx_vld_reg && send_ok) begin
            // offer next byte to admitted hosts
            tx_vld_reg <= 1'b1;
            tx_dat_reg <= mem_reg[rd_ptr_reg[9:0]];
            tx_last_reg <= rd_ptr_reg + CNT_W'(1) == dlen_reg;
            pend_reg <= active; // RULE_18
          end else if (byte_done) begin
            // next byte only after every admitted host took it or was skipped as jammed
            tx_vld_reg <= 1'b0; // RULE_17
            tx_last_reg <= 1'b0;
            pend_reg <= '0;
            rd_ptr_reg <= rd_ptr_reg + CNT_W'(1);
            if (tx_last_reg) begin
              st_reg <= ST_FILL;
              rx_rdy_reg <= 1'b1;
            end
          end else if (tx_vld_reg) begin
            pend_reg <= owed;
          end
        end
      endcase
    end
  end

  // ==========================================
  // network to serial fifo, strict arrival order
  assign push = net_rx_valid_i && nrx_rdy_reg;
  assign pop = fcnt_reg != '0 && (!stx_vld_reg || ser_tx_ready_i);
  assign fcnt_next = fcnt_reg + FW'(push) - FW'(pop);

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      fifo_reg[fwp_reg] <= net_rx_data_i; // RULE_20
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fwp_reg <= '0;
      frp_reg <= '0;
      fcnt_reg <= '0;
      nrx_rdy_reg <= 1'b0;
      stx_vld_reg <= 1'b0;
      stx_dat_reg <= 8'h00;
    end else begin
      fcnt_reg <= fcnt_next;
      nrx_rdy_reg <= fcnt_next < FW'(DEPTH);
      if (push) fwp_reg <= fwp_reg + 1'b1;
      if (pop) begin
        // oldest entry goes out first
        frp_reg <= frp_reg + 1'b1; // RULE_20
        stx_dat_reg <= fifo_reg[frp_reg];
        stx_vld_reg <= 1'b1;
      end else if (ser_tx_ready_i) begin
        stx_vld_reg <= 1'b0;
      end
    end
  end

  // ==========================================
  // link sync and modem lines
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      link_m_reg <= 1'b0;
      link_s_reg <= 1'b0;
    end else begin
      link_m_reg <= link_up_i;
      link_s_reg <= link_m_reg;
    end
  end

  // single host always steers; tunnel only when enabled
  assign cmd_ok = cmd_valid_i && (maxc <= 3'h1 || ctrl_reg[CTRL_DRV]); // RULE_19

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rts_ctl_reg <= 1'b1;
      dtr_ctl_reg <= 1'b1;
      rts_reg <= 1'b1;
      dtr_reg <= 1'b1;
    end else begin
      if (cmd_ok) begin
        rts_ctl_reg <= cmd_rts_i; // RULE_19
        dtr_ctl_reg <= cmd_dtr_i;
      end
      // low option forces both lines down when link lost
      rts_reg <= rts_ctl_reg && !(ctrl_reg[CTRL_LOW] && !link_s_reg); // RULE_16
      dtr_reg <= dtr_ctl_reg && !(ctrl_reg[CTRL_LOW] && !link_s_reg); // RULE_16
    end
  end

  // ==========================================
  // outputs
  assign reg_rdata_o = reg_rdata_reg;
  assign ser_rx_ready_o = rx_rdy_reg;
  assign net_tx_valid_o = tx_vld_reg;
  assign net_tx_data_o = tx_dat_reg;
  assign net_tx_last_o = tx_last_reg;
  assign net_tx_pend_o = pend_reg;
  assign net_rx_ready_o = nrx_rdy_reg;
  assign ser_tx_valid_o = stx_vld_reg;
  assign ser_tx_data_o = stx_dat_reg;
  assign rts_o = rts_reg;
  assign dtr_o = dtr_reg;

  // ==========================================
  // assertions
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_fill_take;
    st_reg == ST_FILL && take;
  endsequence
  sequence s_drain_start;
    st_reg == ST_DRAIN && cnt_reg == '0;
  endsequence

  AST_LEN: assert property (s_fill_take and (len_reg != '0 && cnt_next >= len_reg // RULE_02
    && cnt_next != '0) |=> s_drain_start)
    else $error("length limit did not release");
  AST_NOLIM: assert property (s_fill_take and (len_reg == '0 && !en1 // RULE_01
    && gap_reg == 16'h0000 && cnt_next < FULL_CNT) |=> st_reg == ST_FILL)
    else $error("release without limit");
  AST_DLM1: assert property (s_fill_take and (en1 && !en2 && pol == POL_PLAIN // RULE_03
    && ser_rx_data_i == dlm_reg[7:0]) |=> s_drain_start ##0 dlen_reg == $past(cnt_reg) + 1'b1)
    else $error("delimiter release wrong");
  AST_DLM2: assert property (s_fill_take and (en1 && en2 && !prev_d1_reg // RULE_04
    && len_reg == '0 && trail_reg == 2'h0 && ser_rx_data_i != dlm_reg[7:0]
    && cnt_next < FULL_CNT) |=> st_reg == ST_FILL)
    else $error("released on one delimiter");
  AST_OVER: assert property (st_reg == ST_FILL && store && en1 // RULE_06
    && cnt_reg == FULL_CNT - 1'b1 |=> s_drain_start ##0 dlen_reg == FULL_CNT)
    else $error("no release above one kilobyte");
  AST_NOPOL: assert property (!en1 |-> trail_reg == 2'h0) // RULE_07
    else $error("policy active without delimiter");
  AST_PLUS1: assert property (s_fill_take and (en1 && !en2 && pol == POL_PLUS1 // RULE_09
    && trail_reg == 2'h0 && dcond && len_reg == '0 && cnt_next < FULL_CNT)
    |=> st_reg == ST_FILL && trail_reg == 2'h1)
    else $error("plus one released early");
  AST_PLUS2: assert property (s_fill_take and (en1 && !en2 && pol == POL_PLUS2 // RULE_10
    && trail_reg == 2'h0 && dcond) |=> trail_reg == 2'h2 || st_reg == ST_DRAIN)
    else $error("plus two count wrong");
  AST_STRIP: assert property (s_fill_take and (en1 && !en2 && pol == POL_STRIP // RULE_11
    && dcond && cnt_reg != '0) |=> dlen_reg == $past(cnt_reg))
    else $error("delimiter not stripped");
  AST_GAP0: assert property (gap_reg == 16'h0000 |-> !rel_gap) // RULE_12
    else $error("gap release while disabled");
  AST_CLEAR: assert property (flush |=> cnt_reg == '0 && trail_reg == 2'h0 // RULE_23
    && gap_ms_reg == 17'h00000)
    else $error("release left state behind");
  AST_LINK: assert property (ctrl_reg[CTRL_LOW] && !link_s_reg |=> !rts_o && !dtr_o) // RULE_16
    else $error("modem lines high after link loss");
  AST_JAM: assert property (tx_vld_reg && owed != '0 |=> tx_vld_reg && $stable(tx_dat_reg)) // RULE_17
    else $error("byte dropped before all hosts");
  AST_DGRAM: assert property (st_reg == ST_DRAIN && !tx_vld_reg && !send_ok // RULE_21
    |=> !tx_vld_reg)
    else $error("datagram sent without range");
endmodule // spk_packetizer

/* File: rtl/spk_pkg.sv */
// spk_pkg: constants shared by the serial packetizer
// assumes: a single 50 MHz clock domain
package spk_pkg;
  // ==========================================
  // register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00; // mode bits
  localparam logic [7:0] LEN_OFS = 8'h04; // length limit
  localparam logic [7:0] DLM_OFS = 8'h08; // delimiters
  localparam logic [7:0] GAP_OFS = 8'h0C; // idle gap in ms
  localparam logic [7:0] STAT_OFS = 8'h10; // read-only state
  localparam logic [7:0] RNG_OFS = 8'h20; // range i: +8i begin, +8i+4 end
  // ==========================================
  // field positions
  localparam int CTRL_DGRAM = 0; // datagram mode
  localparam int CTRL_SKIP = 1; // skip jammed hosts
  localparam int CTRL_LOW = 2; // drop rts/dtr on link loss
  localparam int CTRL_DRV = 3; // allow host control commands
  localparam int CTRL_MAXC = 4; // max connections, 3 bits
  localparam int DLM_EN1 = 16; // first delimiter enable
  localparam int DLM_EN2 = 17; // second delimiter enable
  localparam int DLM_POL = 18; // policy, 2 bits
  // ==========================================
  // reset values and sizes
  localparam logic [2:0] MAXC_RST = 3'h1; // one host by default
  localparam logic [1:0] POL_RST = 2'h0; // plain policy
  localparam int BUF_BYTES = 1024; // per-port buffer
  localparam int CNT_W = 11; // holds 0..1024
  localparam int MAX_HOSTS = 4; // fan-out limit
  localparam int NRANGE = 4; // destination ranges
  localparam logic [31:0] RANGE_SPAN = 32'h00000040; // 64 addresses
  localparam logic [7:0] BCAST_OCTET = 8'hFF; // subnet broadcast
  localparam int FIFO_DEPTH = 16; // network to serial
  // ==========================================
  // timing
  localparam int CLK_NS = 20; // clock period
  localparam int MS_UNIT_NS = 1000000; // one millisecond
  localparam int MS_CYC = MS_UNIT_NS / CLK_NS; // cycles per ms
  // ==========================================
  // types
  typedef enum logic [1:0] {POL_PLAIN, POL_PLUS1, POL_PLUS2, POL_STRIP} spk_pol_t;
  typedef enum logic {ST_FILL, ST_DRAIN} spk_st_t;
endpackage

/* File: tb/serial_to_network_packetizer_tb_top.sv */
// serial_to_network_packetizer_tb_top: self-checking bench for spk_packetizer
// assumes: spk_pkg and spk_host_model compiled first; 50 MHz clock
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module serial_to_network_packetizer_tb_top;
  import spk_pkg::*;
  localparam int MSC = 10; // shortened millisecond
  logic sys_clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic ser_rx_valid_i = 1'b0, net_rx_valid_i = 1'b0, cmd_valid_i = 1'b0;
  logic cmd_rts_i = 1'b1, cmd_dtr_i = 1'b1, link_up_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00, ser_rx_data_i = 8'h00, net_rx_data_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, v;
  logic [3:0] host_jam_i = 4'h0, host_ready_i, net_tx_pend_o;
  logic ser_rx_ready_o, net_tx_valid_o, net_tx_last_o, net_rx_ready_o, ser_tx_valid_o;
  logic ser_tx_ready_i, rts_o, dtr_o;
  logic [7:0] net_tx_data_o, ser_tx_data_o;
  logic [31:0] xs = 32'h332D; // xorshift state
  logic [7:0] tx[$]; // bytes to send
  logic [8:0] ex[$]; // expected host bytes with last flag
  int errors = 0, tests_run = 0, cyc = 0;
  always #10 sys_clk_i = ~sys_clk_i;
  spk_packetizer #(.MS_CYCLES(MSC), .DEPTH(FIFO_DEPTH)) u_dut (.sys_clk_i, .rst_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .ser_rx_valid_i, .ser_rx_data_i,
    .ser_rx_ready_o, .net_tx_valid_o, .net_tx_data_o, .net_tx_last_o, .net_tx_pend_o,
    .host_ready_i, .host_jam_i, .net_rx_valid_i, .net_rx_data_i, .net_rx_ready_o,
    .ser_tx_valid_o, .ser_tx_data_o, .ser_tx_ready_i, .cmd_valid_i, .cmd_rts_i, .cmd_dtr_i,
    .link_up_i, .rts_o, .dtr_o);
  spk_host_model u_host (.sys_clk_i, .pend_i(net_tx_pend_o), .data_i(net_tx_data_o),
    .last_i(net_tx_last_o), .jam_i(host_jam_i), .ready_o(host_ready_i),
    .stx_valid_i(ser_tx_valid_o), .stx_data_i(ser_tx_data_o), .stx_ready_o(ser_tx_ready_i));
  // ==========================================
  // helpers: random bytes never match a delimiter
  function automatic logic [7:0] rb();
    xs ^= xs << 13;
    xs ^= xs >> 17;
    xs ^= xs << 5;
    return xs[7:0] | 8'h80;
  endfunction
  // expected packets: cut every n bytes, drop one byte value
  function automatic void expect_pkts(input int cut, input logic [7:0] drop);
    foreach (tx[k]) if (tx[k] !== drop) ex.push_back({cut > 0 && (k + 1) % cut == 0, tx[k]});
    ex[ex.size() - 1][8] = 1'b1;
  endfunction
  task automatic test_done();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================
  // bus and stream drivers
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge sys_clk_i);
    v = reg_rdata_o;
    @(posedge sys_clk_i);
  endtask
  // valid held across bytes; each byte goes at an edge with ready high
  task automatic send_all(input bit net);
    @(posedge sys_clk_i);
    foreach (tx[k]) begin
      if (net) begin
        net_rx_valid_i <= 1'b1;
        net_rx_data_i <= tx[k];
      end else begin
        ser_rx_valid_i <= 1'b1;
        ser_rx_data_i <= tx[k];
      end
      do @(negedge sys_clk_i); while ((net ? net_rx_ready_o : ser_rx_ready_o) !== 1'b1);
      @(posedge sys_clk_i);
    end
    ser_rx_valid_i <= 1'b0;
    net_rx_valid_i <= 1'b0;
  endtask
  task automatic expect_rx();
    int i;
    i = 0;
    while (u_host.got.size() < ex.size() && i < 8000) begin
      @(negedge sys_clk_i);
      i++;
    end
    `CHK(u_host.got.size(), ex.size())
    foreach (ex[k]) if (k < u_host.got.size()) `CHK(u_host.got[k], ex[k])
    u_host.got.delete();
    tx.delete();
    ex.delete();
    @(posedge sys_clk_i);
  endtask
  task automatic cmd(input logic r);
    @(posedge sys_clk_i);
    cmd_rts_i <= r;
    cmd_valid_i <= 1'b1;
    @(posedge sys_clk_i);
    cmd_valid_i <= 1'b0;
    repeat (3) @(negedge sys_clk_i);
  endtask
  // ==========================================
  // hang guard
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      test_done();
    end
  end
  // ==========================================
  // main sequence
  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    rd(CTRL_OFS);
    `CHK(v, 32'h10)
    rd(DLM_OFS);
    `CHK(v[19:18], POL_RST)
    rd(8'h80);
    `CHK(v, 32'h0)
    // full buffer with no limit, no gap, no delimiter
    repeat (BUF_BYTES) tx.push_back(rb());
    expect_pkts(0, 8'h00);
    send_all(0);
    expect_rx();
    wr(LEN_OFS, 32'h3);
    repeat (6) tx.push_back(rb());
    expect_pkts(3, 8'h00);
    send_all(0);
    expect_rx();
    wr(LEN_OFS, 32'h0);
    for (int p = 0; p < 4; p++) begin
      wr(DLM_OFS, {12'h0, p[1:0], 1'b0, 1'b1, 8'h00, 8'h0D});
      repeat (2) tx.push_back(rb());
      tx.push_back(8'h0D);
      repeat (p % 3) tx.push_back(rb());
      expect_pkts(0, (p == 3) ? 8'h0D : 8'h00);
      send_all(0);
      expect_rx();
    end
    // delimiter still enabled: a full buffer must go out anyway
    repeat (BUF_BYTES) tx.push_back(rb());
    expect_pkts(0, 8'h00);
    send_all(0);
    expect_rx();
    wr(DLM_OFS, 32'h00030A0D);
    tx = '{rb(), 8'h0D, rb(), 8'h0D, 8'h0A};
    expect_pkts(0, 8'h00);
    send_all(0);
    expect_rx();
    wr(DLM_OFS, 32'h0);
    wr(GAP_OFS, 32'h2);
    repeat (3) tx.push_back(rb());
    expect_pkts(0, 8'h00);
    send_all(0);
    repeat (2 * MSC) @(negedge sys_clk_i);
    `CHK(u_host.got.size(), 0)
    expect_rx();
    wr(GAP_OFS, 32'h0);
    // two hosts, the second jammed, skipping on
    wr(CTRL_OFS, 32'h22);
    wr(LEN_OFS, 32'h2);
    host_jam_i <= 4'b0010;
    repeat (4) tx.push_back(rb());
    expect_pkts(2, 8'h00);
    send_all(0);
    expect_rx();
    host_jam_i <= 4'h0;
    wr(LEN_OFS, 32'h0);
    wr(CTRL_OFS, 32'h11);
    rd(STAT_OFS);
    `CHK(v[25], 1'b0)
    wr(RNG_OFS, 32'h0A000001);
    wr(RNG_OFS + 8'h04, 32'h0A000041);
    rd(STAT_OFS);
    `CHK(v[21], 1'b0)
    wr(RNG_OFS + 8'h04, 32'h0A000040);
    rd(STAT_OFS);
    `CHK({v[25], v[21]}, 2'b11)
    wr(RNG_OFS + 8'h08, 32'h0A0001FF);
    rd(STAT_OFS);
    `CHK(v[22], 1'b1)
    for (int c = 0; c < 2; c++) begin
      wr(CTRL_OFS, c ? 32'h14 : 32'h10);
      link_up_i <= 1'b0;
      repeat (5) @(negedge sys_clk_i);
      `CHK({rts_o, dtr_o}, {2{c == 0}})
      @(posedge sys_clk_i) link_up_i <= 1'b1;
      repeat (5) @(negedge sys_clk_i);
      `CHK({rts_o, dtr_o}, 2'b11)
    end
    cmd(1'b0);
    `CHK({rts_o, dtr_o}, 2'b01)
    wr(CTRL_OFS, 32'h20);
    cmd(1'b1);
    `CHK({rts_o, dtr_o}, 2'b01)
    // network to serial order
    repeat (6) tx.push_back(rb());
    send_all(1);
    for (int i = 0; i < 400 && u_host.sq.size() < 6; i++) @(negedge sys_clk_i);
    foreach (tx[k]) `CHK(u_host.sq[k], tx[k])
    test_done();
  end
endmodule // serial_to_network_packetizer_tb_top

/* File: tb/spk_host_model.sv */
// spk_host_model: network hosts and serial sink facing the packetizer
// assumes: one clock; only host 0 bytes are recorded, jammed hosts never accept
`timescale 1ns/100ps
module spk_host_model (
  input wire logic sys_clk_i,
  input wire logic [3:0] pend_i,
  input wire logic [7:0] data_i,
  input wire logic last_i,
  input wire logic [3:0] jam_i,
  output logic [3:0] ready_o,
  input wire logic stx_valid_i,
  input wire logic [7:0] stx_data_i,
  output logic stx_ready_o
);
  // ==========================================
  // recorded traffic
  logic [8:0] got[$]; // host 0 bytes, last flag on top
  logic [7:0] sq[$]; // bytes seen by the serial sink
  logic [15:0] lfsr_reg = 16'hACE1; // stall pattern
  initial begin
    ready_o = 4'h0;
    stx_ready_o = 1'b0;
  end
  // ==========================================
  // accept with random stalls; a jammed host stays silent
  always @(posedge sys_clk_i) begin
    if (pend_i[0] && ready_o[0]) got.push_back({last_i, data_i});
    if (stx_valid_i && stx_ready_o) sq.push_back(stx_data_i);
    lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    ready_o <= lfsr_reg[3:0] & ~jam_i;
    stx_ready_o <= lfsr_reg[5];
  end
endmodule // spk_host_model
